//--- hw/serial_frame_map.svh
// constants of the serial frame engine
`ifndef SERIAL_FRAME_MAP_SVH
`define SERIAL_FRAME_MAP_SVH
`define SFE_WORD_BITS 22
`define SFE_CNT_BITS 6
`define SFE_CNT_MAX 6'h3F
`define SFE_WORD_ZERO 22'h00_0000
`define SFE_OP_MSB 21
`define SFE_OP_LSB 17
`define SFE_ADDR_MSB 16
`define SFE_ADDR_LSB 8
`define SFE_DATA_MSB 7
`define SFE_DATA_LSB 0
`define SFE_OP_RD_REG 5'h11
`define SFE_RESULT_LSB 2
`define SFE_REG_LSB 14
`define SFE_READY_DELAY_NS 100
`define SFE_READY_DELAY_CYC ((`SFE_READY_DELAY_NS + 49) / 50)
`endif

//--- hw/serial_frame_pkg.sv
// types of the serial frame engine
package serial_frame_pkg;
    typedef struct packed {
        logic [4:0] opcode;
        logic [8:0] addr;
        logic [7:0] data;
    } cmd_word_t;
    typedef struct packed {
        logic valid;
        cmd_word_t word;
    } cmd_out_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FRAME = 2'b01,
        ST_WAIT = 2'b10
    } frame_state_t;
    typedef enum logic [1:0] {
        SRC_RESULT = 2'b00,
        SRC_REG = 2'b01,
        SRC_PATTERN = 2'b10
    } word_src_t;
endpackage

//--- hw/link_shifter.sv
// link-clock shift logic: input capture, edge count, output launch
`timescale 1ns/100ps
`include "serial_frame_map.svh"
module link_shifter (
    input wire logic i_sclk,
    input wire logic i_cs_b,
    input wire logic i_sdi,
    input wire logic [21:0] i_load_word,
    output logic o_sdo,
    output logic [21:0] o_in_word,
    output logic [5:0] o_count,
    output logic o_fresh
);
    import serial_frame_pkg::*;
    typedef struct packed {
        logic [21:0] in_sr;
        logic [21:0] out_sr;
        logic [5:0] cnt;
    } link_state_t;
    link_state_t st;
    link_state_t next_st;
    logic fresh;
    // fresh is set by select itself: the link clock stands still outside
    // frames, so no link edge can be relied on to mark a frame boundary
    always_comb begin
        next_st = st;
        if (fresh) begin
            next_st.cnt = 6'h01; // count restarts at one, counting this edge
            next_st.in_sr = {21'h00_0000, i_sdi}; // cleared, then first bit
            next_st.out_sr = {i_load_word[20:0], 1'b0};
        end else begin
            next_st.in_sr = {st.in_sr[20:0], i_sdi}; // last 22 bits kept
            if (st.cnt != `SFE_CNT_MAX) begin
                next_st.cnt = st.cnt + 6'h01; // saturating
            end
            next_st.out_sr = {st.out_sr[20:0], 1'b0}; // msb first
        end
    end
    always_ff @(posedge i_sclk) begin
        st <= next_st;
    end
    always_ff @(posedge i_sclk or posedge i_cs_b) begin
        if (i_cs_b) begin
            fresh <= 1'b1;
        end else begin
            fresh <= 1'b0;
        end
    end
    // word and count hold after select rise, until the next first edge
    assign o_in_word = st.in_sr;
    assign o_count = st.cnt;
    assign o_fresh = fresh;
    // first bit is the loaded msb before any clock
    assign o_sdo = fresh ? i_load_word[21] : st.out_sr[21];
endmodule // link_shifter

//--- hw/adc_serial_frame_engine.sv
// serial frame engine: frame control, classification, command hand-off
// Functional notes
// - frame runs from select fall to rise
// - frame accepted regardless of convert-start
// - ready strobe low at frame start
// - edge counter restarted at first link edge of frame
// - output word loaded at frame start
// - input register cleared to no-op
// - each capture edge counts and shifts; the edge count saturates at 63
// - each launch edge shifts output bit
// - end: output released, ready after delay
// - end: input word passed to processor
// - under 22 edges: no-op frame
// - exactly 22 edges: valid command
// - over 22: last 22 bits executed
// - short frame output bits stay valid
// - internal clock launch, external capture
// - result loaded only at frame start
// - bits 21..2 carry latest result
// - after read, register then zeros
// - opcode, address, data field split
`timescale 1ns/100ps
`include "serial_frame_map.svh"
module adc_serial_frame_engine (
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_sclk,
    input wire logic i_cs_b,
    input wire logic i_sdi,
    input wire logic i_int_clk_sel,
    input wire logic i_int_launch,
    input wire logic [19:0] i_result,
    input wire logic i_result_valid,
    input wire logic [7:0] i_reg_rdata,
    input wire logic i_pattern_en,
    input wire logic [19:0] i_pattern,
    input wire logic [1:0] i_parity,
    output logic o_ready_strobe,
    output logic o_sdo,
    output logic o_sdo_oe_b,
    output serial_frame_pkg::cmd_out_t o_cmd
);
    import serial_frame_pkg::*;
    typedef struct packed {
        frame_state_t fsm;
        logic [2:0] cs_sync;
        logic [21:0] load_word;
        logic [19:0] latest;
        logic rd_pending;
        logic [7:0] wait_cnt;
        logic ready;
        logic sdo;
        logic sdo_oe_b;
        logic [21:0] int_sr;
        logic [1:0] sdo_sync;
        logic [1:0] fresh_sync;
        logic got_clk;
        cmd_out_t cmd;
    } eng_state_t;
    eng_state_t st;
    eng_state_t next_st;
    logic [21:0] link_word;
    logic [5:0] link_count;
    logic link_sdo;
    logic link_fresh;
    function automatic cmd_word_t split_cmd(input logic [21:0] w);
        split_cmd.opcode = w[`SFE_OP_MSB:`SFE_OP_LSB];
        split_cmd.addr = w[`SFE_ADDR_MSB:`SFE_ADDR_LSB];
        split_cmd.data = w[`SFE_DATA_MSB:`SFE_DATA_LSB];
    endfunction
    link_shifter u_link (
        .i_sclk(i_sclk),
        .i_cs_b(i_cs_b),
        .i_sdi(i_sdi),
        .i_load_word(st.load_word),
        .o_sdo(link_sdo),
        .o_in_word(link_word),
        .o_count(link_count),
        .o_fresh(link_fresh)
    );
    // word and count are stable once select is high; sampled only then,
    // with select synchronised first so they have settled
    always_comb begin
        next_st = st;
        next_st.cmd.valid = 1'b0;
        next_st.cs_sync = {st.cs_sync[1:0], i_cs_b};
        next_st.sdo_sync = {st.sdo_sync[0], link_sdo};
        next_st.fresh_sync = {st.fresh_sync[0], link_fresh};
        if (i_result_valid) begin
            next_st.latest = i_result; // held until the next valid result
        end
        case (st.fsm)
            ST_IDLE: begin
                if (!st.cs_sync[2]) begin // any time, convert-start ignored
                    next_st.fsm = ST_FRAME;
                    next_st.ready = 1'b0;
                    next_st.sdo_oe_b = 1'b0;
                    next_st.int_sr = st.load_word;
                    next_st.got_clk = 1'b0;
                end
            end
            ST_FRAME: begin
                // a frame without link edges leaves the old count standing
                if (!st.fresh_sync[1]) begin
                    next_st.got_clk = 1'b1;
                end
                if (i_int_clk_sel && i_int_launch) begin
                    next_st.int_sr = {st.int_sr[20:0], 1'b0};
                end
                next_st.sdo = i_int_clk_sel ? st.int_sr[21] : st.sdo_sync[1];
                if (st.cs_sync[2]) begin
                    next_st.fsm = ST_WAIT;
                    next_st.sdo_oe_b = 1'b1; // released
                    next_st.wait_cnt = 8'(`SFE_READY_DELAY_CYC);
                    next_st.rd_pending = 1'b0;
                    if (st.got_clk && link_count >= 6'(`SFE_WORD_BITS)) begin
                        next_st.cmd.valid = 1'b1;
                        next_st.cmd.word = split_cmd(link_word);
                        next_st.rd_pending = (split_cmd(link_word).opcode == 5'(`SFE_OP_RD_REG));
                    end
                end
            end
            ST_WAIT: begin
                // the next word is built here so it is ready before any new frame
                if (i_pattern_en) begin
                    next_st.load_word = {i_pattern, i_parity};
                end else if (st.rd_pending) begin
                    next_st.load_word = {i_reg_rdata, 14'h0000};
                end else begin
                    next_st.load_word = {st.latest, i_parity};
                end
                if (st.wait_cnt <= 8'h01) begin
                    next_st.ready = 1'b1;
                    next_st.fsm = ST_IDLE;
                end else begin
                    next_st.wait_cnt = st.wait_cnt - 8'h01;
                end
            end
            default: begin
                next_st.fsm = ST_IDLE;
            end
        endcase
        if (st.fsm == ST_IDLE) begin
            next_st.load_word = i_pattern_en ? {i_pattern, i_parity}
                : st.rd_pending ? {i_reg_rdata, 14'h0000} : {st.latest, i_parity};
        end
    end
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            st <= '0;
            st.cs_sync <= 3'h7;
            st.ready <= 1'b1;
            st.sdo_oe_b <= 1'b1;
            st.fsm <= ST_IDLE;
        end else begin
            st <= next_st;
        end
    end
    assign o_ready_strobe = st.ready;
    assign o_sdo = st.sdo;
    assign o_sdo_oe_b = st.sdo_oe_b;
    assign o_cmd = st.cmd;
endmodule // adc_serial_frame_engine

//--- verif/adc_serial_frame_engine_assertions.sv
// frame engine port checker
`timescale 1ns/100ps
module frame_engine_checker (
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_cs_b,
    input wire logic o_ready_strobe,
    input wire logic o_sdo_oe_b,
    input wire serial_frame_pkg::cmd_out_t o_cmd
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);
    ready_drop_a: assert property ($fell(i_cs_b) |-> ##[1:4] !o_ready_strobe) else $error("ready stays high");
    bus_take_a: assert property ($fell(i_cs_b) |-> ##[1:4] !o_sdo_oe_b) else $error("bus not taken");
    bus_release_a: assert property ($rose(i_cs_b) |-> ##[1:4] o_sdo_oe_b) else $error("bus kept");
    ready_return_a: assert property ($rose(i_cs_b) |-> ##[1:8] o_ready_strobe) else $error("ready late");
    frame_busy_a: assert property (!i_cs_b && !o_sdo_oe_b |-> !o_ready_strobe) else $error("ready in frame");
    cmd_after_end_a: assert property (o_cmd.valid |-> i_cs_b && $past(i_cs_b, 2)) else $error("early command");
    cmd_pulse_a: assert property (o_cmd.valid |=> !o_cmd.valid) else $error("long command");
    cmd_then_ready_a: assert property (o_cmd.valid |-> !o_ready_strobe ##[1:4] o_ready_strobe)
        else $error("ready order");
    cover property ($rose(o_cmd.valid));
    cover property ($fell(i_cs_b));
    cover property ($rose(i_cs_b) ##6 !o_cmd.valid);
endmodule // frame_engine_checker
bind adc_serial_frame_engine frame_engine_checker chk (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_cs_b(i_cs_b),
    .o_ready_strobe(o_ready_strobe), .o_sdo_oe_b(o_sdo_oe_b), .o_cmd(o_cmd));

//--- verif/host_model.sv
// host controller: frames on chip select, link clock and data in
`timescale 1ns/100ps
module host_model (
    output logic o_cs_b,
    output logic o_sclk,
    output logic o_sdi
);
    initial begin
        o_cs_b = 1'b1;
        o_sclk = 1'b0;
        o_sdi = 1'b0;
    end
    // link clock stands low outside frames; data msb first
    // clock and select static between frames, data toggled at select rise; frames placed while results arrive
    task automatic frame(input int n, input logic [63:0] b, input int half);
        #7 o_cs_b = 1'b0;
        #210;
        for (int i = n - 1; i >= 0; i--) begin
            o_sdi = b[i];
            #half o_sclk = 1'b1;
            #half o_sclk = 1'b0;
        end
        #30 o_cs_b = 1'b1;
        o_sdi = ~o_sdi;
    endtask
endmodule // host_model

//--- verif/adc_serial_frame_engine_test.sv
// self-checking bench of the serial frame engine
`timescale 1ns/100ps
module adc_serial_frame_engine_test;
    import serial_frame_pkg::*;
    int fails = 0;
    int compares = 0;
    int seen = 0;
    int lens[7] = '{21, 22, 23, 0, 70, 1, 20}; // 1: msb-only read frame
    logic [21:0] got;
    logic i_mclk = 1'b0, i_rst_b = 1'b0, i_sclk, i_cs_b, i_sdi, i_result_valid = 1'b0, i_pattern_en = 1'b0;
    logic [19:0] i_result = 20'h0_0000, i_pattern = 20'h0_0000;
    logic [7:0] i_reg_rdata = 8'h00;
    logic [1:0] i_parity = 2'h0;
    logic o_ready_strobe, o_sdo, o_sdo_oe_b;
    cmd_out_t o_cmd;
    always #25 i_mclk = ~i_mclk;
    host_model host (.o_cs_b(i_cs_b), .o_sclk(i_sclk), .o_sdi(i_sdi));
    adc_serial_frame_engine uut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_sclk(i_sclk), .i_cs_b(i_cs_b),
        .i_sdi(i_sdi), .i_int_clk_sel(1'b0), .i_int_launch(1'b0), .i_result(i_result),
        .i_result_valid(i_result_valid), .i_reg_rdata(i_reg_rdata), .i_pattern_en(i_pattern_en),
        .i_pattern(i_pattern), .i_parity(i_parity), .o_ready_strobe(o_ready_strobe), .o_sdo(o_sdo),
        .o_sdo_oe_b(o_sdo_oe_b), .o_cmd(o_cmd));
    always @(negedge i_mclk) begin
        if (i_rst_b) begin
            i_result <= 20'($urandom);
            i_result_valid <= 1'($urandom);
            i_reg_rdata <= 8'($urandom);
            i_pattern_en <= 1'($urandom);
            i_pattern <= 20'($urandom);
            i_parity <= 2'($urandom);
        end
    end
    always @(negedge i_mclk) begin
        if (o_cmd.valid === 1'b1) begin
            seen++;
            got = o_cmd.word;
        end
    end
    task check(input logic [63:0] val, input logic [63:0] exp);
        compares++;
        if (val !== exp) begin
            fails++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, val, exp);
        end
    endtask
    task stop_test();
        if (fails == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // a frame executes only from the 22nd capture edge on
    function automatic int exp_count(input int n);
        return (n >= 22) ? 1 : 0;
    endfunction
    initial begin
        int n;
        int k;
        logic [63:0] b;
        void'($urandom(94));
        repeat (4) @(negedge i_mclk);
        i_rst_b = 1'b1;
        repeat (4) @(negedge i_mclk);
        for (int t = 0; t < 16; t++) begin
            n = (t < 7) ? lens[t] : $urandom_range(40, 1);
            b = {$urandom, $urandom};
            k = 0;
            while (o_ready_strobe !== 1'b1 && k < 100) begin
                @(negedge i_mclk);
                k++;
            end
            if (k == 100) begin
                fails++;
                stop_test();
            end
            seen = 0;
            host.frame(n, b, 24);
            repeat (12) @(negedge i_mclk);
            check(seen, exp_count(n));
            if (n >= 22)
                check(got, b[21:0]);
            check({o_ready_strobe, o_sdo_oe_b}, 2'b11);
        end
        stop_test();
    end
endmodule // adc_serial_frame_engine_test
